/* rtl/dmbdc_map.svh */
`ifndef DMBDC_MAP_SVH
`define DMBDC_MAP_SVH

// mode register select codes on the bank address pins
`define DMBDC_BA_MR0 3'h0
`define DMBDC_BA_MR1 3'h1
`define DMBDC_BA_MR2 3'h2

// mode register 0 field positions
`define DMBDC_MR0_BL_LO  0
`define DMBDC_MR0_BL_HI  1
`define DMBDC_MR0_BT     3
`define DMBDC_MR0_DLLRST 8
`define DMBDC_MR0_WR_LO  9
`define DMBDC_MR0_WR_HI  11
`define DMBDC_MR0_PPD    12

// mode register 1 and 2 field positions
`define DMBDC_MR1_DLLDIS   0
`define DMBDC_MR1_WLVL     7
`define DMBDC_MR2_RTTWR_LO 9
`define DMBDC_MR2_RTTWR_HI 10

// address pins sampled with read and write commands
`define DMBDC_BC_PIN 12
`define DMBDC_AP_PIN 10

// burst length field codes
`define DMBDC_BL_FIX8 2'h0
`define DMBDC_BL_OTF  2'h1
`define DMBDC_BL_FIX4 2'h2

// link cycles from write command to internal write start
`define DMBDC_WS_BL8 8
`define DMBDC_WS_BC4 6

// default counts
`define DMBDC_DLLK_CYC 512
`define DMBDC_TRP_CYC  8'h05
`define DMBDC_WR_BASE  8'h04

// reset values of the mode fields
`define DMBDC_RST_BL     2'h0
`define DMBDC_RST_DLLDIS 1'b1

`endif

/* rtl/dmbdc_pkg.sv */
package dmbdc_pkg;

  // command pins as sampled on the link clock
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [12:0] addr;
  } dmbdc_cmd_t;

  // one beat slot of a burst
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       drive;
    logic       keep;
    logic [2:0] col;
  } dmbdc_beat_t;

  typedef enum logic [2:0] {
    dll_off,
    dll_locking,
    dll_locked,
    dll_frozen,
    dll_sleep
  } dmbdc_dll_t;

  // status levels handed to the reference domain
  typedef struct packed {
    logic       dll_on;
    logic       dll_locked;
    logic       dll_frozen;
    logic       self_ref;
    logic       pwr_down;
    logic       wr_need_dll;
    logic       wr_dll_ok;
    logic [1:0] bl;
    logic       bt;
    logic       ppd_fast;
    logic       wlvl;
  } dmbdc_status_t;

  // all state on the link clock
  typedef struct packed {
    logic          rst_s1;
    logic          rst_s2;
    logic          rst_s3;
    logic          rst_f;
    logic [1:0]    bl;
    logic          bt;
    logic          dll_rst;
    logic [2:0]    wr;
    logic          ppd;
    logic          dll_dis;
    logic          wlvl;
    logic [1:0]    rtt_wr;
    dmbdc_dll_t    dll;
    logic [15:0]   lock_cnt;
    logic          cke_q;
    logic          sref;
    logic          pdn;
    logic          busy;
    logic          bwrite;
    logic          bchop;
    logic [2:0]    slot;
    logic [2:0]    start;
    logic          ws_run;
    logic          ws_ap;
    logic [3:0]    ws_cnt;
    logic          dal_run;
    logic [7:0]    dal_cnt;
    dmbdc_beat_t   beat;
    logic          wr_start;
    logic          dal_done;
    dmbdc_status_t stat;
  } dmbdc_link_t;

  // all state on the reference clock
  typedef struct packed {
    dmbdc_status_t s1;
    dmbdc_status_t s2;
    dmbdc_status_t s3;
    dmbdc_status_t out;
  } dmbdc_ref_t;

endpackage

/* rtl/dmbdc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmbdc_map.svh"

module dmbdc_ctrl
  import dmbdc_pkg::*;
#(
  parameter int         DLLK_CYC = `DMBDC_DLLK_CYC,
  parameter logic [7:0] TRP_CYC  = `DMBDC_TRP_CYC,
  parameter logic [7:0] WR_BASE  = `DMBDC_WR_BASE
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          link_clk,
  input  wire dmbdc_cmd_t    cmd,
  output var  dmbdc_beat_t   beat,
  output logic               wr_start,
  output logic               dal_done,
  output var  dmbdc_status_t status
);

  localparam int WS4 = `DMBDC_WS_BC4;
  localparam int WS8 = `DMBDC_WS_BL8;
  localparam int SW  = $bits(dmbdc_status_t);

  dmbdc_link_t lq;
  dmbdc_link_t ld;
  dmbdc_ref_t  rq;
  dmbdc_ref_t  rd;

  logic        link_rst;
  logic        live;
  logic        mrs;
  logic        is_rd;
  logic        is_wr;
  logic        sre;
  logic        pde;
  logic        cke_up;
  logic        acc;
  logic        acc_wr;
  logic [1:0]  lo2;
  logic [7:0]  wr_cyc;
  logic [SW-1:0] v2;
  logic [SW-1:0] v3;
  logic [SW-1:0] vo;

  assign link_rst = lq.rst_f;

  // link-side next state: mode fields, dll, burst engine, write timing
  always_comb begin
    ld     = lq;
    lo2    = 2'h0;
    wr_cyc = 8'h00;
    // reset synchroniser; a change counts once stages two and three agree
    ld.rst_s1 = rst;
    ld.rst_s2 = lq.rst_s1;
    ld.rst_s3 = lq.rst_s2;
    if (lq.rst_s2 == lq.rst_s3) begin
      ld.rst_f = lq.rst_s3;
    end
    ld.beat     = '0;
    ld.wr_start = 1'b0;
    ld.dal_done = 1'b0;
    ld.dll_rst  = 1'b0;
    ld.cke_q    = cmd.cke;

    // command decode while clock enable stays high; power entry and exit on its edges
    live   = cmd.cke && lq.cke_q && !cmd.cs_n;
    mrs    = live && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    is_rd  = live && cmd.ras_n && !cmd.cas_n && cmd.we_n;
    is_wr  = live && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    sre    = lq.cke_q && !cmd.cke && !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
    pde    = lq.cke_q && !cmd.cke && !sre;
    cke_up = !lq.cke_q && cmd.cke;

    // dll lock countdown; reads are legal only once this expires, though the burst engine accepts reads in any dll state
    if (lq.dll == dll_locking) begin
      if (lq.lock_cnt == 16'h0000) begin
        ld.dll = dll_locked;
      end else begin
        ld.lock_cnt = lq.lock_cnt - 16'h0001;
      end
    end

    // mode register writes; the bank pins select the register
    if (mrs) begin
      case (cmd.ba)
        `DMBDC_BA_MR0: begin
          ld.bl  = cmd.addr[`DMBDC_MR0_BL_HI:`DMBDC_MR0_BL_LO];
          ld.bt  = cmd.addr[`DMBDC_MR0_BT];
          ld.wr  = cmd.addr[`DMBDC_MR0_WR_HI:`DMBDC_MR0_WR_LO];
          ld.ppd = cmd.addr[`DMBDC_MR0_PPD];
          if (cmd.addr[`DMBDC_MR0_DLLRST]) begin
            ld.dll_rst = 1'b1;
            if (!lq.dll_dis) begin
              ld.dll      = dll_locking;
              ld.lock_cnt = 16'(DLLK_CYC - 1);
            end
          end
        end
        `DMBDC_BA_MR1: begin
          ld.dll_dis = cmd.addr[`DMBDC_MR1_DLLDIS];
          ld.wlvl    = cmd.addr[`DMBDC_MR1_WLVL];
          if (cmd.addr[`DMBDC_MR1_DLLDIS]) begin
            ld.dll = dll_off;
          end else if (lq.dll == dll_off) begin
            ld.dll      = dll_locking;
            ld.lock_cnt = 16'(DLLK_CYC - 1);
          end
        end
        `DMBDC_BA_MR2: begin
          ld.rtt_wr = cmd.addr[`DMBDC_MR2_RTTWR_HI:`DMBDC_MR2_RTTWR_LO];
        end
        default: begin
        end
      endcase
    end

    // power-down and self-refresh entry on the falling clock enable
    if (sre) begin
      ld.sref = 1'b1;
      if (!lq.dll_dis) begin
        ld.dll = dll_sleep;
      end
    end else if (pde) begin
      ld.pdn = 1'b1;
      if (!lq.ppd && lq.dll == dll_locked) begin
        ld.dll = dll_frozen;
      end
    end
    // exit on the rising clock enable
    if (cke_up) begin
      ld.sref = 1'b0;
      ld.pdn  = 1'b0;
      if (lq.dll == dll_sleep) begin
        ld.dll      = dll_locking;
        ld.lock_cnt = 16'(DLLK_CYC - 1);
      end else if (lq.dll == dll_frozen) begin
        ld.dll = dll_locked;
      end
    end

    // burst engine; a new access may follow the last slot back to back
    acc    = (is_rd || is_wr) && (!lq.busy || lq.slot == 3'h7);
    acc_wr = acc && is_wr;
    if (acc) begin
      ld.busy   = 1'b1;
      ld.slot   = 3'h0;
      ld.start  = cmd.addr[2:0];
      ld.bwrite = is_wr;
      ld.bchop  = (lq.bl == `DMBDC_BL_FIX4) ||
                  (lq.bl == `DMBDC_BL_OTF && !cmd.addr[`DMBDC_BC_PIN]);
    end else if (lq.busy) begin
      ld.slot = lq.slot + 3'h1;
      ld.busy = (lq.slot != 3'h7);
    end

    // beat column and driver state for the slot just set up
    if (ld.busy) begin
      ld.beat.valid = 1'b1;
      ld.beat.write = ld.bwrite;
      if (ld.bwrite) begin
        ld.beat.drive = 1'b0;
        if (ld.bchop) begin
          ld.beat.col  = {ld.start[2], ld.slot[1:0]};
          ld.beat.keep = !ld.slot[2];
        end else begin
          ld.beat.col  = ld.slot;
          ld.beat.keep = 1'b1;
        end
      end else begin
        if (lq.bt) begin
          lo2 = ld.start[1:0] ^ ld.slot[1:0];
        end else begin
          lo2 = ld.start[1:0] + ld.slot[1:0];
        end
        ld.beat.col   = {ld.start[2] ^ ld.slot[2], lo2};
        ld.beat.drive = !(ld.bchop && ld.slot[2]);
        ld.beat.keep  = 1'b0;
      end
    end

    // internal write start, pulled in only for fixed chop 4
    wr_cyc = {5'h00, lq.wr} + WR_BASE;
    if (acc_wr) begin
      ld.ws_run = 1'b1;
      ld.ws_ap  = cmd.addr[`DMBDC_AP_PIN];
      if (lq.bl == `DMBDC_BL_FIX4) begin
        ld.ws_cnt = 4'(WS4 - 1);
      end else begin
        ld.ws_cnt = 4'(WS8 - 1);
      end
    end else if (lq.ws_run) begin
      if (lq.ws_cnt == 4'h1) begin
        ld.wr_start = 1'b1;
        ld.ws_run   = 1'b0;
        if (lq.ws_ap) begin
          ld.dal_run = 1'b1;
          ld.dal_cnt = wr_cyc + TRP_CYC - 8'h01;
        end
      end else begin
        ld.ws_cnt = lq.ws_cnt - 4'h1;
      end
    end
    // auto-precharge write-to-activate countdown
    if (lq.dal_run && !(lq.ws_run && lq.ws_cnt == 4'h1 && lq.ws_ap)) begin
      if (lq.dal_cnt == 8'h00) begin
        ld.dal_done = 1'b1;
        ld.dal_run  = 1'b0;
      end else begin
        ld.dal_cnt = lq.dal_cnt - 8'h01;
      end
    end

    // status levels for the reference domain
    ld.stat.dll_on      = (ld.dll != dll_off) && (ld.dll != dll_sleep);
    ld.stat.dll_locked  = (ld.dll == dll_locked);
    ld.stat.dll_frozen  = (ld.dll == dll_frozen);
    ld.stat.self_ref    = ld.sref;
    ld.stat.pwr_down    = ld.pdn;
    ld.stat.wr_need_dll = (ld.rtt_wr != 2'h0);
    ld.stat.wr_dll_ok   = (ld.rtt_wr == 2'h0) || (ld.dll == dll_locked);
    ld.stat.bl          = ld.bl;
    ld.stat.bt          = ld.bt;
    ld.stat.ppd_fast    = ld.ppd;
    ld.stat.wlvl        = ld.wlvl;

    // synchronous reset keeps the reset synchroniser running
    if (lq.rst_f) begin
      ld         = '0;
      ld.rst_s1  = rst;
      ld.rst_s2  = lq.rst_s1;
      ld.rst_s3  = lq.rst_s2;
      ld.rst_f   = (lq.rst_s2 == lq.rst_s3) ? lq.rst_s3 : lq.rst_f;
      ld.bl      = `DMBDC_RST_BL;
      ld.dll_dis = `DMBDC_RST_DLLDIS;
      ld.dll     = dll_off;
    end
  end

  // link-side state register
  always_ff @(posedge link_clk) begin
    lq <= ld;
  end

  // reference side: three-stage status synchroniser with agreement filter
  always_comb begin
    rd    = rq;
    rd.s1 = lq.stat;
    rd.s2 = rq.s1;
    rd.s3 = rq.s2;
    v2    = rq.s2;
    v3    = rq.s3;
    vo    = rq.out;
    for (int i = 0; i < SW; i++) begin
      if (v2[i] == v3[i]) begin
        vo[i] = v3[i];
      end
    end
    rd.out = vo;
    if (rst) begin
      rd = '0;
    end
  end

  // reference-side state register
  always_ff @(posedge ref_clk) begin
    rq <= rd;
  end

  // outputs straight from flops
  assign beat     = lq.beat;
  assign wr_start = lq.wr_start;
  assign dal_done = lq.dal_done;
  assign status   = rq.out;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (link_rst);

  // write start counts: 6 link cycles for fixed chop 4, 8 otherwise
  sequence s_wr_fix4;
    acc_wr && lq.bl == `DMBDC_BL_FIX4;
  endsequence
  sequence s_wr_otf;
    acc_wr && lq.bl == `DMBDC_BL_OTF;
  endsequence
  sequence s_dll_pulse;
    lq.dll_rst ##1 !lq.dll_rst;
  endsequence
  il_order_a: assert property (
    lq.beat.valid && !lq.beat.write && lq.bt |-> lq.beat.col == (lq.start ^ lq.slot))
    else $error("interleaved read column wrong");
  seq_group_a: assert property (
    lq.beat.valid && !lq.beat.write && !lq.bt |->
      lq.beat.col[2] == (lq.start[2] ^ lq.slot[2]) &&
      lq.beat.col[1:0] == 2'(lq.start[1:0] + lq.slot[1:0]))
    else $error("sequential read column wrong");
  wr_order_a: assert property (
    lq.beat.valid && lq.beat.write && !lq.bchop |-> lq.beat.col == lq.slot && lq.beat.keep)
    else $error("burst 8 write column wrong");
  chop_tri_a: assert property (
    acc && is_rd && lq.bl == `DMBDC_BL_FIX4 |-> ##1 lq.beat.drive [*4] ##1 !lq.beat.drive [*4])
    else $error("chop read drive pattern wrong");
  chop_wr_a: assert property (
    lq.beat.valid && lq.beat.write && lq.bchop |->
      lq.beat.col[2] == lq.start[2] && lq.beat.keep == !lq.slot[2])
    else $error("chop write half or mask wrong");
  wr_pull_a: assert property (
    s_wr_fix4 |-> !lq.wr_start [*6] ##1 lq.wr_start)
    else $error("fixed chop write start not pulled in");
  wr_otf_a: assert property (
    s_wr_otf |-> !lq.wr_start [*8] ##1 lq.wr_start)
    else $error("on the fly write start moved");
  dll_clear_a: assert property (
    mrs && cmd.ba == `DMBDC_BA_MR0 && cmd.addr[`DMBDC_MR0_DLLRST] |=> s_dll_pulse)
    else $error("dll reset bit not self clearing");
  sref_off_a: assert property (
    sre && !lq.dll_dis |=> lq.dll == dll_sleep ##1 !lq.stat.dll_on)
    else $error("dll still on in self refresh");
  ppd_slow_a: assert property (
    pde && !lq.ppd && lq.dll == dll_locked |=> lq.dll == dll_frozen)
    else $error("slow exit did not freeze dll");
  ppd_fast_a: assert property (
    pde && lq.ppd && lq.dll == dll_locked |=> lq.dll == dll_locked)
    else $error("fast exit stopped dll");
  dll_en_a: assert property (
    mrs && cmd.ba == `DMBDC_BA_MR1 |=> (lq.dll == dll_off) == lq.dll_dis)
    else $error("dll enable bit not followed");
  dal_len_a: assert property (
    lq.wr_start && $rose(lq.dal_run) |->
      lq.dal_cnt == 8'({5'h00, lq.wr} + WR_BASE + TRP_CYC - 8'h01))
    else $error("write to activate delay wrong");

endmodule
`default_nettype wire

/* bench/dmbdc_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmbdc_map.svh"

module dmbdc_ctl_model
  import dmbdc_pkg::*;
(
  input  wire logic link_clk,
  output var  dmbdc_cmd_t cmd
);
  // idle: deselect with cke high
  initial begin
    cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 13'h0000};
  end

  // one command for one link edge, then deselect with inverted address so stale values never pass
  task automatic send(input dmbdc_cmd_t c);
    @(posedge link_clk);
    cmd <= c;
    @(posedge link_clk);
    cmd <= '{c.cke, 1'b1, 1'b1, 1'b1, 1'b1, ~c.ba, ~c.addr};
  endtask

  // mode register set, reserved bits forced to zero
  task automatic mrs(input logic [2:0] ba, input logic [12:0] a);
    logic [12:0] m;
    m = (ba == `DMBDC_BA_MR0) ? 13'h1F7F : (ba == `DMBDC_BA_MR1) ? 13'h1AFF : 13'h06FF;
    send('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ba, a & m});
  endtask

  // read or write
  task automatic access(input logic wr, input logic [12:0] a);
    send('{1'b1, 1'b0, 1'b1, 1'b0, ~wr, 3'h0, a});
  endtask

  // cke change: entry with cke low, exit with cke high; sref picks self-refresh code
  task automatic power(input logic cke, input logic sref);
    send('{cke, ~sref, ~sref, ~sref, 1'b1, 3'h0, 13'h0000});
  endtask

  // dll off: dll disabled first, write termination switched off after
  task automatic dll_disable();
    mrs(`DMBDC_BA_MR1, 13'h0001);
    mrs(`DMBDC_BA_MR2, 13'h0000);
  endtask
endmodule

`default_nettype wire

/* bench/ddr3_mode_burst_dll_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmbdc_map.svh"

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module ddr3_mode_burst_dll_control_tb
  import dmbdc_pkg::*;
;
  localparam int DLLK = 40;
  logic          ref_clk;
  logic          link_clk;
  logic          rst;
  dmbdc_cmd_t    cmd;
  dmbdc_beat_t   beat;
  logic          wr_start;
  logic          dal_done;
  dmbdc_status_t status;
  logic [12:0]   mr0;
  int            err_total;
  int            n_checks;
  int            cyc;

  dmbdc_ctrl #(.DLLK_CYC(DLLK)) i_dut (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .link_clk (link_clk),
    .cmd      (cmd),
    .beat     (beat),
    .wr_start (wr_start),
    .dal_done (dal_done),
    .status   (status)
  );

  dmbdc_ctl_model i_ctl (
    .link_clk (link_clk),
    .cmd      (cmd)
  );

  // clocks with unrelated phase
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // run limit
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_ref(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // program mode register 0 with write recovery code 2
  task automatic set_mr0(input logic [1:0] bl, input logic bt, input logic ppd, input logic dr);
    mr0 = {ppd, 3'h2, dr, 4'h0, bt, 1'b0, bl};
    i_ctl.mrs(`DMBDC_BA_MR0, mr0);
    wait_ref(8);
  endtask

  // one access, then every slot, write start and precharge delay checked for 24 link edges
  task automatic burst(input logic wr, input logic [12:0] a);
    int          ws;
    int          dal;
    logic        chop;
    logic [2:0]  s;
    logic [2:0]  k;
    logic [2:0]  c;
    s = a[2:0];
    chop = (mr0[1:0] == `DMBDC_BL_FIX4) || (mr0[1:0] == `DMBDC_BL_OTF && !a[12]);
    ws = (mr0[1:0] == `DMBDC_BL_FIX4) ? `DMBDC_WS_BC4 : `DMBDC_WS_BL8;
    dal = ws + `DMBDC_WR_BASE + mr0[11:9] + `DMBDC_TRP_CYC;
    i_ctl.access(wr, a);
    // slot k shows just after the edge that took the command plus k
    for (int e = 1; e <= 24; e++) begin
      if (e > 1) @(posedge link_clk);
      #1;
      if (e <= 8) begin
        k = 3'(e - 1);
        if (wr) c = chop ? {s[2], k[1:0]} : k;
        else if (mr0[3]) c = s ^ k;
        else c = {s[2] ^ k[2], s[1:0] + k[1:0]};
        `CHK(beat.valid, 1'b1)
        `CHK(beat.write, wr)
        if (wr) `CHK(beat.keep, ~(chop & k[2]))
        else `CHK(beat.drive, ~(chop & k[2]))
        if (!(chop && k[2])) `CHK(beat.col, c)
      end else `CHK(beat.valid, 1'b0)
      `CHK(wr_start, wr && e == ws)
      `CHK(dal_done, wr && a[10] && e == dal)
    end
  endtask

  initial begin
    rst = 1'b1;
    mr0 = 13'h0000;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge link_clk);
    wait_ref(6);
    `CHK(status.dll_on, 1'b0)
    `CHK(status.bl, `DMBDC_RST_BL)
    // dll on, then reset and relock
    i_ctl.mrs(`DMBDC_BA_MR1, 13'h0000);
    wait_ref(40);
    `CHK(status.dll_on, 1'b1)
    `CHK(status.dll_locked, 1'b1)
    set_mr0(`DMBDC_BL_FIX8, 1'b0, 1'b0, 1'b1);
    `CHK(status.dll_locked, 1'b0)
    wait_ref(35);
    `CHK(status.dll_locked, 1'b1)
    // every burst length code and type, every start column, reads and writes
    for (int i = 0; i < 4; i++) begin
      for (int t = 0; t < 2; t++) begin
        set_mr0(2'(i), t[0], 1'b0, 1'b0);
        `CHK(status.bl, 2'(i))
        `CHK(status.bt, t[0])
        `CHK(status.dll_locked, 1'b1)
        for (int j = 0; j < 8; j++) begin
          burst(1'b0, {j[1], 9'h000, 3'(j)});
          burst(1'b1, {j[0], 1'b0, t[0], 7'h00, 3'(j)});
        end
      end
    end
    // precharge power-down, slow and fast exit
    for (int p = 0; p < 2; p++) begin
      set_mr0(`DMBDC_BL_FIX8, 1'b0, p[0], 1'b0);
      `CHK(status.ppd_fast, p[0])
      i_ctl.power(1'b0, 1'b0);
      wait_ref(8);
      `CHK(status.pwr_down, 1'b1)
      `CHK(status.dll_frozen, ~p[0])
      i_ctl.power(1'b1, 1'b0);
      wait_ref(8);
      `CHK(status.dll_frozen, 1'b0)
      `CHK(status.dll_locked, 1'b1)
    end
    // self-refresh stops the dll, exit relocks it
    i_ctl.power(1'b0, 1'b1);
    wait_ref(8);
    `CHK(status.self_ref, 1'b1)
    `CHK(status.dll_locked, 1'b0)
    i_ctl.power(1'b1, 1'b0);
    wait_ref(8);
    `CHK(status.self_ref, 1'b0)
    wait_ref(35);
    `CHK(status.dll_locked, 1'b1)
    // write leveling with allowed termination, write termination on
    i_ctl.mrs(`DMBDC_BA_MR1, 13'h0084);
    i_ctl.mrs(`DMBDC_BA_MR2, 13'h0200);
    wait_ref(8);
    `CHK(status.wlvl, 1'b1)
    `CHK(status.wr_need_dll, 1'b1)
    `CHK(status.wr_dll_ok, 1'b1)
    // dll relocking with write termination on: writes not yet safe
    set_mr0(`DMBDC_BL_FIX8, 1'b0, 1'b0, 1'b1);
    `CHK(status.wr_dll_ok, 1'b0)
    i_ctl.dll_disable();
    wait_ref(8);
    `CHK(status.dll_on, 1'b0)
    `CHK(status.wr_need_dll, 1'b0)
    test_done();
  end
endmodule

`default_nettype wire
